// File: common/ivs_pkg.sv
package ivs_pkg;
  // ****************************************************
  // Register indices (byte address = 4 * index)
  // ****************************************************
  localparam int          IVS_AW        = 18;
  localparam logic [15:0] IVS_IDX_PEND1 = 16'hFE04;
  localparam logic [15:0] IVS_IDX_PEND2 = 16'hFE05;
  localparam logic [15:0] IVS_IDX_PEND3 = 16'hFE06;
  localparam logic [15:0] IVS_IDX_EVST  = 16'hFE10;
  localparam logic [15:0] IVS_IDX_EVMSK = 16'hFE11;
  localparam logic [15:0] IVS_IDX_SRCEN = 16'hFE12;
  localparam logic [15:0] IVS_IDX_SPTR  = 16'hFE13;

  // ****************************************************
  // Sources, flags and vectors
  // ****************************************************
  // Source order: ext irq, ch0, ch1, wrap, keypad, converter
  localparam int          IVS_NSRC = 6;
  localparam logic [15:0] IVS_VEC [IVS_NSRC] =
    '{16'hFFFA, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFE0, 16'hFFDE};
  localparam int          IVS_FLAG [IVS_NSRC] = '{1, 3, 4, 5, 14, 15};
  localparam logic [15:0] IVS_VEC_SWI = 16'hFFFC;
  localparam logic [15:0] IVS_SP_RST  = 16'h00FF;
  localparam logic [15:0] IVS_ONE16   = 16'h0001;
  localparam logic [5:0]  IVS_SRCEN_RST = 6'h3F;

  // ****************************************************
  // Byte counts and event bits
  // ****************************************************
  localparam logic [2:0] IVS_N_ENTRY = 3'h5;
  localparam logic [2:0] IVS_N_CALL  = 3'h2;
  localparam logic [2:0] IVS_CNT_ONE = 3'h1;
  localparam int         IVS_NEV     = 3;
  localparam int         IVS_EV_ENTRY = 0;
  localparam int         IVS_EV_CALL  = 1;
  localparam int         IVS_EV_PULL  = 2;

  typedef struct packed {
    logic [7:0] ccr;
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] pch;
    logic [7:0] pcl;
  } ivs_regs_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ivs_mem_t;

  typedef enum logic [1:0] {IVS_OP_ENTRY, IVS_OP_CALL, IVS_OP_RTI, IVS_OP_RTS} ivs_op_t;
endpackage

// File: src/ivs_core.sv
// Contract
// - Converter vector low at FFDF, lowest priority
// - Timer wrap vector at FFF2/FFF3
// - Timer channel one vector at FFF4/FFF5
// - Channel zero at FFF6/FFF7, above channel one
// - Interrupt entry pushes exactly five bytes
// - Upper index byte never stacked
// - Subroutine call pushes two return bytes
// - Pointer decrements on push, increments on pull
// - Stack pointer is sixteen bits wide
// - Three pending status registers from FE04
`timescale 1ns/1ps
module ivs_core
  import ivs_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  // Avalon-MM slave
  input  wire logic [IVS_AW-1:0]     avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output logic                       irq,
  // Peripheral request levels
  input  wire logic [IVS_NSRC-1:0]   src_req,
  // Core side
  input  wire logic                  op_req,
  input  wire ivs_op_t               op_kind,
  input  wire logic                  op_swi,
  input  wire ivs_regs_t             op_regs,
  output logic                       op_busy,
  output logic                       op_done,
  output logic                       irq_pending,
  output logic [15:0]                vector_r,
  output ivs_regs_t                  pulled_r,
  output logic [15:0]                sp_r,
  // Stack RAM and vector memory, read data one cycle later
  output ivs_mem_t                   mem,
  input  wire logic [7:0]            mem_rdata
);

  // ****************************************************
  // Declarations
  // ****************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_PUSH, ST_PULL, ST_PDONE, ST_VHI, ST_VLO, ST_VEND
  } ivs_st_t;

  ivs_st_t                state_r;
  ivs_op_t                kind_r;
  logic [2:0]             cnt_r;
  logic [39:0]            push_r;
  logic [15:0]            vaddr_r;
  logic                   rd_pend_r;
  logic [IVS_NEV-1:0]     ev_r;
  logic [IVS_NEV-1:0]     mask_r;
  logic [IVS_NEV-1:0]     ev_set;
  logic [5:0]             srcen_r;
  logic [15:0]            pend;
  logic [IVS_NSRC-1:0]    act;
  logic [15:0]            sel_vec;
  logic                   sel_any;
  logic                   ack_r;
  logic                   bus_req;
  logic                   bus_wr;
  logic [15:0]            idx;
  logic [31:0]            rd_mux;

  assign idx     = avs_address[17:2];
  assign bus_req = (avs_read | avs_write) & ~ack_r;
  // Writes land on the edge where waitrequest is low, as the master sees it
  assign bus_wr  = avs_write & ack_r;

  // ****************************************************
  // Pending sources and priority
  // ****************************************************
  assign act = src_req & srcen_r;

  // Map each source onto its flag number position
  always_comb begin
    pend = 16'h0000;
    for (int i = 0; i < IVS_NSRC; i++) begin
      pend[IVS_FLAG[i]] = act[i];
    end
  end

  // Scan from lowest priority up so the highest one wins
  always_comb begin
    sel_vec = IVS_VEC_SWI;
    sel_any = 1'b0;
    for (int i = IVS_NSRC - 1; i >= 0; i--) begin
      if (act[i]) begin
        sel_vec = IVS_VEC[i];
        sel_any = 1'b1;
      end
    end
  end

  assign irq_pending = sel_any;

  // ****************************************************
  // Sequencer
  // ****************************************************
  // Source is latched at entry start; later requests wait
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      kind_r  <= IVS_OP_ENTRY;
      cnt_r   <= 3'h0;
      push_r  <= 40'h00_0000_0000;
      vaddr_r <= 16'h0000;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (op_req) begin
            kind_r <= op_kind;
            vaddr_r <= (op_swi | ~sel_any) ? IVS_VEC_SWI : sel_vec;
            push_r <= op_regs;
            unique case (op_kind)
              IVS_OP_ENTRY: begin
                cnt_r   <= IVS_N_ENTRY;
                state_r <= ST_PUSH;
              end
              IVS_OP_CALL: begin
                cnt_r   <= IVS_N_CALL;
                state_r <= ST_PUSH;
              end
              IVS_OP_RTI: begin
                cnt_r   <= IVS_N_ENTRY;
                state_r <= ST_PULL;
              end
              IVS_OP_RTS: begin
                cnt_r   <= IVS_N_CALL;
                state_r <= ST_PULL;
              end
            endcase
          end
        end
        ST_PUSH: begin
          // Low byte first: PCL, PCH, X, A, CCR
          push_r <= {8'h00, push_r[39:8]};
          cnt_r  <= cnt_r - IVS_CNT_ONE;
          if (cnt_r == IVS_CNT_ONE) begin
            state_r <= (kind_r == IVS_OP_ENTRY) ? ST_VHI : ST_IDLE;
          end
        end
        ST_PULL: begin
          cnt_r <= cnt_r - IVS_CNT_ONE;
          if (cnt_r == IVS_CNT_ONE) begin
            state_r <= ST_PDONE;
          end
        end
        ST_PDONE: state_r <= ST_IDLE;
        ST_VHI:   state_r <= ST_VLO;
        ST_VLO:   state_r <= ST_VEND;
        ST_VEND:  state_r <= ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  assign op_busy = (state_r != ST_IDLE);

  // Done pulses once per finished operation
  always_comb begin
    op_done = 1'b0;
    ev_set  = '0;
    if (state_r == ST_VEND) begin
      op_done = 1'b1;
      ev_set[IVS_EV_ENTRY] = 1'b1;
    end
    if (state_r == ST_PUSH && cnt_r == IVS_CNT_ONE && kind_r == IVS_OP_CALL) begin
      op_done = 1'b1;
      ev_set[IVS_EV_CALL] = 1'b1;
    end
    if (state_r == ST_PDONE) begin
      op_done = 1'b1;
      ev_set[IVS_EV_PULL] = 1'b1;
    end
  end

  // ****************************************************
  // Memory port
  // ****************************************************
  // Push writes at the pointer; pull reads one above it
  always_comb begin
    mem = '0;
    unique case (state_r)
      ST_PUSH: begin
        mem.en    = 1'b1;
        mem.we    = 1'b1;
        mem.addr  = sp_r;
        mem.wdata = push_r[7:0];
      end
      ST_PULL: begin
        mem.en   = 1'b1;
        mem.addr = sp_r + IVS_ONE16;
      end
      ST_VHI: begin
        mem.en   = 1'b1;
        mem.addr = vaddr_r;
      end
      ST_VLO: begin
        mem.en   = 1'b1;
        mem.addr = vaddr_r + IVS_ONE16;
      end
      default: mem = '0;
    endcase
  end

  // Read data arrives one cycle after the request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_r <= 1'b0;
      vector_r  <= 16'h0000;
      pulled_r  <= '0;
    end else begin
      rd_pend_r <= mem.en & ~mem.we;
      if (rd_pend_r) begin
        if (state_r == ST_VLO || state_r == ST_VEND) begin
          vector_r <= {vector_r[7:0], mem_rdata};
        end else begin
          pulled_r <= {pulled_r[31:0], mem_rdata};
        end
      end
    end
  end

  // ****************************************************
  // Stack pointer
  // ****************************************************
  // Software writes are dropped while a sequence runs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_r <= IVS_SP_RST;
    end else if (state_r == ST_PUSH) begin
      sp_r <= sp_r - IVS_ONE16;
    end else if (state_r == ST_PULL) begin
      sp_r <= sp_r + IVS_ONE16;
    end else if (state_r == ST_IDLE && bus_wr && idx == IVS_IDX_SPTR) begin
      if (avs_byteenable[0]) sp_r[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) sp_r[15:8] <= avs_writedata[15:8];
    end
  end

  // ****************************************************
  // Register file
  // ****************************************************
  // Sticky events: a new event beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_r <= '0;
    end else begin
      if (bus_wr && idx == IVS_IDX_EVST && avs_byteenable[0]) begin
        ev_r <= (ev_r & ~avs_writedata[IVS_NEV-1:0]) | ev_set;
      end else begin
        ev_r <= ev_r | ev_set;
      end
    end
  end

  // Mask and source enables
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r  <= '0;
      srcen_r <= IVS_SRCEN_RST;
    end else if (bus_wr && avs_byteenable[0]) begin
      if (idx == IVS_IDX_EVMSK) mask_r <= avs_writedata[IVS_NEV-1:0];
      if (idx == IVS_IDX_SRCEN) srcen_r <= avs_writedata[5:0];
    end
  end

  assign irq = |(ev_r & mask_r);

  // Read decode; unmapped indices read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      IVS_IDX_PEND1: rd_mux[7:0] = pend[8:1];
      IVS_IDX_PEND2: rd_mux[6:0] = pend[15:9];
      IVS_IDX_PEND3: rd_mux = 32'h0000_0000;
      IVS_IDX_EVST:  rd_mux[IVS_NEV-1:0] = ev_r;
      IVS_IDX_EVMSK: rd_mux[IVS_NEV-1:0] = mask_r;
      IVS_IDX_SRCEN: rd_mux[5:0] = srcen_r;
      IVS_IDX_SPTR:  rd_mux[15:0] = sp_r;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait state on every access
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      if (avs_read && !ack_r) avs_readdata <= rd_mux;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

endmodule

// File: bench/ivs_mem_model.sv
`timescale 1ns/1ps
module ivs_mem_model
  import ivs_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Memory port
  input  wire ivs_mem_t   mem,
  output logic [7:0]      mem_rdata
);
  logic [7:0] ram [65536];
  // Fill so every vector byte is known and distinct
  initial begin
    mem_rdata = 8'h00;
    for (int i = 0; i < 65536; i++) ram[i] = 8'(i) ^ 8'h5A;
  end
  // Idle data flips so a mistimed sample cannot match
  always @(posedge sys_clk) begin
    if (mem.en && mem.we) ram[mem.addr] <= mem.wdata;
    mem_rdata <= (mem.en && !mem.we) ? ram[mem.addr] : ~mem_rdata;
  end
endmodule

// File: bench/ivs_core_props.sv
`timescale 1ns/1ps
module ivs_core_props
  import ivs_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  // Core side
  input  wire logic [IVS_NSRC-1:0] src_req,
  input  wire logic                op_req,
  input  wire ivs_op_t             op_kind,
  input  wire logic                op_swi,
  input  wire ivs_regs_t           op_regs,
  input  wire logic                op_busy,
  input  wire logic                op_done,
  input  wire logic [15:0]         sp_r,
  input  wire ivs_mem_t            mem,
  input  wire logic                irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic te;
  logic tc;
  ivs_regs_t te_regs;
  // Accepted entry and call requests
  assign te = op_req && !op_busy && op_kind == IVS_OP_ENTRY;
  assign tc = op_req && !op_busy && op_kind == IVS_OP_CALL;
  // Registers captured at entry take; busy keeps them steady for the push
  always_ff @(posedge sys_clk) begin
    if (te) te_regs <= op_regs;
  end
  property p_entry_len; te |-> ##8 op_done; endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry length wrong");
  property p_entry_five; te |=> (mem.en && mem.we)[*5] ##1 !mem.we; endproperty
  a_entry_five: assert property (p_entry_five) else $error("entry push count wrong");
  property p_entry_data;
    te |=> mem.wdata == te_regs.pcl ##1 mem.wdata == te_regs.pch
      ##1 mem.wdata == te_regs.x ##1 mem.wdata == te_regs.a ##1 mem.wdata == te_regs.ccr;
  endproperty
  a_entry_data: assert property (p_entry_data) else $error("stacked bytes wrong");
  property p_call_two; tc |=> mem.we ##1 (mem.we && op_done) ##1 !mem.we; endproperty
  a_call_two: assert property (p_call_two) else $error("call push count wrong");
  property p_push_dec;
    mem.en && mem.we |-> mem.addr == sp_r ##1 sp_r == $past(sp_r) - IVS_ONE16;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push pointer wrong");
  property p_vec_pair;
    te |-> ##6 (mem.en && !mem.we) ##1 (mem.en && !mem.we && mem.addr == $past(mem.addr) + 1);
  endproperty
  a_vec_pair: assert property (p_vec_pair) else $error("vector pair fetch wrong");
  property p_ch0_first; te && !op_swi && src_req == 6'h06 |-> ##6 mem.addr == 16'hFFF6; endproperty
  a_ch0_first: assert property (p_ch0_first) else $error("channel order wrong");
  property p_conv_lo; te && !op_swi && src_req == 6'h20 |-> ##7 mem.addr == 16'hFFDF; endproperty
  a_conv_lo: assert property (p_conv_lo) else $error("converter low byte wrong");
  property p_prio; te && !op_swi && src_req == 6'h30 |-> ##6 mem.addr == 16'hFFE0; endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");
  c_entry: cover property (te);
  c_call: cover property (tc);
  c_irq: cover property ($rose(irq));
endmodule
bind ivs_core ivs_core_props u_props (.sys_clk, .arst_n, .src_req, .op_req, .op_kind, .op_swi,
  .op_regs, .op_busy, .op_done, .sp_r, .mem, .irq);

// File: bench/ivs_core_tb.sv
`timescale 1ns/1ps
module ivs_core_tb import ivs_pkg::*;;
  logic sys_clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, op_req = 0, op_swi = 0;
  logic irq, op_busy, op_done, irq_pending, avs_waitrequest;
  logic [IVS_AW-1:0]   avs_address = '0;
  logic [31:0]         avs_writedata = '0, avs_readdata, rd;
  logic [3:0]          avs_byteenable = 4'hF;
  logic [IVS_NSRC-1:0] src_req = '0;
  ivs_op_t             op_kind = IVS_OP_ENTRY;
  ivs_regs_t           op_regs = '0, pulled_r;
  logic [15:0]         vector_r, sp_r;
  ivs_mem_t            mem;
  logic [7:0]          mem_rdata;
  int                  err_count = 0, compares = 0;
  ivs_core dut (.sys_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .src_req, .op_req, .op_kind,
    .op_swi, .op_regs, .op_busy, .op_done, .irq_pending, .vector_r, .pulled_r, .sp_r, .mem,
    .mem_rdata);
  ivs_mem_model u_mem (.sys_clk, .mem, .mem_rdata);
  // 250 MHz clock
  initial forever #2 sys_clk = ~sys_clk;
  function automatic logic [7:0] vb(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Bus cycle; request held until the rising edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // One core operation; held until taken, results read one edge after done
  task automatic op(input ivs_op_t k, input logic s, input logic [39:0] r);
    @(posedge sys_clk);
    op_req <= 1'b1;
    op_kind <= k;
    op_swi <= s;
    op_regs <= r;
    do @(posedge sys_clk); while (op_busy !== 1'b0);
    op_req <= 1'b0;
    do @(posedge sys_clk); while (op_done !== 1'b1);
    @(posedge sys_clk);
  endtask
  task automatic t_regs;
    bus(0, IVS_IDX_SPTR, 0); chk(rd, 32'h00FF);
    chk(irq_pending, 1'b0);
    bus(0, IVS_IDX_PEND3, 0); chk(rd, 32'h0);
    bus(0, 16'hFE07, 0); chk(rd, 32'h0);
    src_req <= 6'h0E;
    bus(0, IVS_IDX_PEND1, 0); chk(rd, 32'h1C);
    chk(irq_pending, 1'b1);
    src_req <= 6'h30;
    bus(0, IVS_IDX_PEND2, 0); chk(rd, 32'h60);
    // Disabled sources must vanish from status and pending
    bus(1, IVS_IDX_SRCEN, 32'h0);
    bus(0, IVS_IDX_PEND2, 0); chk({irq_pending, rd}, 33'h0);
    bus(1, IVS_IDX_SRCEN, 32'h3F);
  endtask
  task automatic t_entry;
    logic [15:0] v [7] = '{16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFE0, 16'hFFDE, 16'hFFFA, 16'hFFFC};
    logic [5:0]  s [7] = '{6'h06, 6'h04, 6'h08, 6'h30, 6'h20, 6'h01, 6'h3F};
    bus(1, IVS_IDX_SPTR, 32'h00F0);
    for (int i = 0; i < 7; i++) begin
      src_req <= s[i];
      op(IVS_OP_ENTRY, i == 6, 40'h1122334455 + i);
      chk(vector_r, {vb(v[i]), vb(v[i] + 1)});
    end
    chk(sp_r, 16'h00CD);
    chk(u_mem.ram[16'h00F0], 8'h55);
    chk(u_mem.ram[16'h00EB], 8'h56);
  endtask
  task automatic t_pull;
    op(IVS_OP_RTI, 0, 0);
    chk(pulled_r, 40'h112233445B);
    chk(sp_r, 16'h00D2);
  endtask
  // Call raises an event; mask, raise and clear the interrupt
  task automatic t_call;
    bus(1, IVS_IDX_EVST, 32'h7);
    bus(1, IVS_IDX_EVMSK, 32'h0);
    op(IVS_OP_CALL, 0, 40'h000000CDEF);
    bus(0, IVS_IDX_EVST, 0); chk(rd, 32'h2);
    chk({sp_r, u_mem.ram[16'h00D2], u_mem.ram[16'h00D1]}, 32'h00D0EFCD);
    chk(irq, 1'b0);
    bus(1, IVS_IDX_EVMSK, 32'h2);
    @(negedge sys_clk);
    chk(irq, 1'b1);
    op(IVS_OP_RTS, 0, 0);
    chk({sp_r, pulled_r[15:0]}, 32'h00D2CDEF);
    bus(1, IVS_IDX_EVST, 32'h7);
    @(negedge sys_clk);
    chk(irq, 1'b0);
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_entry();
    t_pull();
    t_call();
    stop_test();
  end
  // Watchdog well beyond the hundred and fifty or so cycles needed
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
endmodule
